// ==== rtl/plsc_cfg.svh ====
`ifndef PLSC_CFG_SVH
`define PLSC_CFG_SVH

// ==========================================================
// Clock and timing
`define PLSC_CLK_HZ 40000000
`define PLSC_LAMP_MS 2000
`define PLSC_HOLD_MS 3000
`define PLSC_IDLE_S 360
`define PLSC_DEB_MS 10

// ==========================================================
// Level input positions, top (3a) to bottom (3e)
`define PLSC_LV_A 4
`define PLSC_LV_B 3
`define PLSC_LV_C 2
`define PLSC_LV_D 1
`define PLSC_LV_E 0

// ==========================================================
// Factory values and storage words
`define PLSC_MODE_RST 1'h0
`define PLSC_CNT_RST 2'h2
`define PLSC_NV_MODE 1'h0
`define PLSC_NV_CNT 1'h1

// ==========================================================
// Menu items
`define PLSC_IT_MODE 2'h0
`define PLSC_IT_CNT 2'h1
`define PLSC_IT_PEN 2'h2
`define PLSC_IT_EXIT 2'h3

`endif

// ==== rtl/plsc_pkg.sv ====
package plsc_pkg;

  typedef enum logic [1:0] {
    ST_LAMP = 2'h0,
    ST_MAIN = 2'h1,
    ST_MENU = 2'h3,
    ST_EDIT = 2'h2
  } plsc_state_t;

  typedef struct packed {
    logic mode;
    logic [1:0] count;
  } plsc_params_t;

endpackage

// ==== rtl/plsc_nvm.sv ====
`timescale 1ns/100ps
`include "plsc_cfg.svh"

module plsc_nvm
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic we,
  input wire logic addr,
  input wire logic [1:0] wdata,
  output logic [1:0] rdata
);

  // Array has no reset: it must keep its words across a reset
  logic [1:0] mem [0:1];
  logic [1:0] next_rdata;

  initial
  begin
    mem[`PLSC_NV_MODE] = {1'h0, `PLSC_MODE_RST};
    mem[`PLSC_NV_CNT] = `PLSC_CNT_RST;
  end

  always_ff @(posedge core_clk)
  begin
    if (we)
      mem[addr] <= wdata;
  end

  always_comb
  begin
    next_rdata = mem[addr];
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rdata <= 2'h0;
    else
      rdata <= next_rdata;
  end

endmodule // plsc_nvm

// ==== rtl/plsc_top.sv ====
`timescale 1ns/100ps
`include "plsc_cfg.svh"

module plsc_top
  import plsc_pkg::*;
#(
  parameter logic [27:0] LAMP_CYC = 28'(64'(`PLSC_LAMP_MS) * 64'(`PLSC_CLK_HZ) / 64'd1000),
  parameter logic [27:0] HOLD_CYC = 28'(64'(`PLSC_HOLD_MS) * 64'(`PLSC_CLK_HZ) / 64'd1000),
  parameter logic [35:0] IDLE_CYC = 36'(64'(`PLSC_IDLE_S) * 64'(`PLSC_CLK_HZ)),
  parameter logic [19:0] DEB_CYC = 20'(64'(`PLSC_DEB_MS) * 64'(`PLSC_CLK_HZ) / 64'd1000)
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [4:0] level_raw,
  input wire logic btn_raw,
  input wire logic knob_step,
  input wire logic knob_dir,
  output logic [2:0] pump_run,
  output logic [3:0] lamp,
  output logic alarm_high,
  output logic alarm_low,
  output logic [4:0] level_disp,
  output logic standby_ind,
  output logic backlight,
  output plsc_state_t ui_state,
  output logic [1:0] menu_item,
  output logic [1:0] edit_val,
  output logic param_unlocked,
  output logic refused,
  output plsc_params_t params
);

  function automatic logic [2:0] plsc_mask(input logic [1:0] cnt);
    plsc_mask = (cnt == 2'h1) ? 3'h1 : (cnt == 2'h3) ? 3'h7 : 3'h3;
  endfunction

  // ==========================================================
  // Debounce
  logic [5:0] raw;
  logic [5:0] deb;
  logic [4:0] lv;
  logic btn_q;

  assign raw = {btn_raw, level_raw};
  assign lv = deb[4:0];
  assign btn_q = deb[5];

  genvar gi;
  for (gi = 0; gi < 6; gi++)
  begin : g_deb
    logic [19:0] cnt;
    logic [19:0] next_cnt;
    logic st;
    logic next_st;
    always_comb
    begin
      next_cnt = 20'h0;
      next_st = st;
      if (raw[gi] != st)
      begin
        if (cnt == DEB_CYC - 20'h1)
          next_st = raw[gi];
        else
          next_cnt = cnt + 20'h1;
      end
    end
    always_ff @(posedge core_clk or negedge resetn)
    begin
      if (!resetn)
      begin
        cnt <= 20'h0;
        st <= 1'h0;
      end
      else
      begin
        cnt <= next_cnt;
        st <= next_st;
      end
    end
    assign deb[gi] = st;
  end

  // ==========================================================
  // Operator interface and start-up
  plsc_state_t state, next_state;
  logic [27:0] lamp_cnt, next_lamp_cnt, hold_cnt, next_hold_cnt;
  logic [35:0] idle_cnt, next_idle_cnt;
  logic [2:0] rst_step, next_rst_step;
  logic [1:0] item, next_item, eval, next_eval;
  logic param_en, next_param_en, next_backlight, next_refused, btn_prev, next_btn_prev;
  logic nv_we, next_nv_we, nv_addr, next_nv_addr;
  logic [1:0] nv_wdata, next_nv_wdata, nv_rdata;
  plsc_params_t par, next_par;
  logic press, any_in, hold_hit, idle_hit, busy, guarded;

  assign press = btn_q & ~btn_prev;
  assign any_in = (btn_q ^ btn_prev) | knob_step;
  assign hold_hit = btn_q && (hold_cnt == HOLD_CYC - 28'h1);
  assign idle_hit = !any_in && (idle_cnt == IDLE_CYC - 36'h1);
  assign busy = (pump_run != 3'h0);
  assign guarded = (item == `PLSC_IT_MODE) || (item == `PLSC_IT_CNT);

  plsc_nvm u_nvm
  (
    .core_clk(core_clk),
    .resetn(resetn),
    .we(nv_we),
    .addr(nv_addr),
    .wdata(nv_wdata),
    .rdata(nv_rdata)
  );

  always_comb
  begin
    next_state = state;
    next_lamp_cnt = lamp_cnt;
    next_rst_step = rst_step;
    next_item = item;
    next_eval = eval;
    next_param_en = param_en;
    next_par = par;
    next_backlight = backlight | any_in;
    next_refused = 1'h0;
    next_nv_we = 1'h0;
    next_nv_addr = nv_addr;
    next_nv_wdata = nv_wdata;
    next_btn_prev = btn_q;
    next_hold_cnt = !btn_q ? 28'h0 : (hold_cnt == HOLD_CYC) ? hold_cnt : hold_cnt + 28'h1;
    next_idle_cnt = any_in ? 36'h0 : (idle_cnt == IDLE_CYC) ? idle_cnt : idle_cnt + 36'h1;
    unique case (state)
      ST_LAMP:
      begin
        next_lamp_cnt = lamp_cnt + 28'h1;
        if (rst_step != 3'h4)
          next_rst_step = rst_step + 3'h1;
        // Read data is registered, so each word arrives one cycle after nv_addr holds its address
        if (rst_step == 3'h1)
        begin
          next_par.mode = nv_rdata[0];
          next_nv_addr = `PLSC_NV_CNT;
        end
        if (rst_step == 3'h3)
          next_par.count = (nv_rdata == 2'h0) ? `PLSC_CNT_RST : nv_rdata;
        if (lamp_cnt == LAMP_CYC - 28'h1)
          next_state = ST_MAIN;
      end
      ST_MAIN:
      begin
        if (hold_hit)
        begin
          next_state = ST_MENU;
          next_item = `PLSC_IT_MODE;
        end
      end
      ST_MENU:
      begin
        if (knob_step)
          next_item = knob_dir ? item + 2'h1 : item - 2'h1;
        else if (press)
        begin
          if (item == `PLSC_IT_EXIT)
            next_state = ST_MAIN;
          else if (item == `PLSC_IT_PEN)
          begin
            next_state = ST_EDIT;
            next_eval = {1'h0, param_en};
          end
          else if (!param_en || busy)
            next_refused = 1'h1;
          else
          begin
            next_state = ST_EDIT;
            next_eval = (item == `PLSC_IT_MODE) ? {1'h0, par.mode} : par.count;
          end
        end
      end
      ST_EDIT:
      begin
        if (knob_step)
        begin
          if (item == `PLSC_IT_CNT)
            next_eval = knob_dir ? ((eval == 2'h3) ? 2'h1 : eval + 2'h1)
                                 : ((eval == 2'h1) ? 2'h3 : eval - 2'h1);
          else
            next_eval = {1'h0, ~eval[0]};
        end
        else if (press)
        begin
          next_state = ST_MENU;
          if (item == `PLSC_IT_PEN)
            next_param_en = eval[0];
          else if (busy)
            next_refused = 1'h1;
          else
          begin
            next_nv_we = 1'h1;
            next_nv_addr = (item == `PLSC_IT_MODE) ? `PLSC_NV_MODE : `PLSC_NV_CNT;
            next_nv_wdata = eval;
            if (item == `PLSC_IT_MODE)
              next_par.mode = eval[0];
            else
              next_par.count = eval;
          end
        end
      end
    endcase
    if (idle_hit)
    begin
      next_backlight = 1'h0;
      next_param_en = 1'h0;
      if (state != ST_LAMP)
        next_state = ST_MAIN;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_LAMP;
      lamp_cnt <= 28'h0;
      rst_step <= 3'h0;
      item <= `PLSC_IT_MODE;
      eval <= 2'h0;
      param_en <= 1'h0;
      par <= '{mode: `PLSC_MODE_RST, count: `PLSC_CNT_RST};
      backlight <= 1'h1;
      refused <= 1'h0;
      nv_we <= 1'h0;
      nv_addr <= `PLSC_NV_MODE;
      nv_wdata <= 2'h0;
      btn_prev <= 1'h0;
      hold_cnt <= 28'h0;
      idle_cnt <= 36'h0;
      standby_ind <= 1'h0;
    end
    else
    begin
      state <= next_state;
      lamp_cnt <= next_lamp_cnt;
      rst_step <= next_rst_step;
      item <= next_item;
      eval <= next_eval;
      param_en <= next_param_en;
      par <= next_par;
      backlight <= next_backlight;
      refused <= next_refused;
      nv_we <= next_nv_we;
      nv_addr <= next_nv_addr;
      nv_wdata <= next_nv_wdata;
      btn_prev <= next_btn_prev;
      hold_cnt <= next_hold_cnt;
      idle_cnt <= next_idle_cnt;
      standby_ind <= (next_state != ST_LAMP);
    end
  end

  assign ui_state = state;
  assign menu_item = item;
  assign edit_val = eval;
  assign param_unlocked = param_en;
  assign params = par;

  // ==========================================================
  // Pump switching
  logic [2:0] next_run;
  logic [3:0] next_lamp;

  always_comb
  begin
    next_run = 3'h0;
    if (state != ST_LAMP)
    begin
      if (!par.mode)
      begin
        // Hysteresis: a running pump holds until the stop input goes dry
        next_run[0] = lv[`PLSC_LV_E] & (lv[`PLSC_LV_C] | (pump_run[0] & lv[`PLSC_LV_D]));
        next_run[1] = lv[`PLSC_LV_E] & (lv[`PLSC_LV_B] | (pump_run[1] & lv[`PLSC_LV_D]));
      end
      else
      begin
        next_run[0] = ~lv[`PLSC_LV_B] & (~lv[`PLSC_LV_C] | pump_run[0]);
        next_run[1] = ~lv[`PLSC_LV_B] & (~lv[`PLSC_LV_D] | pump_run[1]);
      end
      // A third pump has no level input of its own and runs alongside pump 2
      next_run[2] = next_run[1];
      next_run = next_run & plsc_mask(par.count);
    end
    next_lamp = (next_state == ST_LAMP) ? 4'hf : {lv[`PLSC_LV_A], next_run};
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pump_run <= 3'h0;
      lamp <= 4'hf;
      alarm_high <= 1'h0;
      alarm_low <= 1'h0;
      level_disp <= 5'h0;
    end
    else
    begin
      pump_run <= next_run;
      lamp <= next_lamp;
      alarm_high <= lv[`PLSC_LV_A];
      alarm_low <= ~lv[`PLSC_LV_E];
      level_disp <= lv;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_enter_menu;
    state == ST_MAIN ##1 state == ST_MENU;
  endsequence

  AST_LAMP_ON: assert property (state == ST_LAMP |-> lamp == 4'hf)
    else $error("lamp test not lit");
  AST_LAMP_LEN: assert property ($rose(standby_ind) |-> lamp_cnt == LAMP_CYC)
    else $error("lamp test length wrong");
  AST_STANDBY: assert property (standby_ind == (state != ST_LAMP))
    else $error("standby indication wrong");
  AST_RESUME: assert property (rst_step == 3'h2 |-> par.mode == $past(nv_rdata[0]))
    else $error("mode not restored");
  AST_IDLE: assert property (idle_hit |=> !backlight && !param_en && state != ST_MENU)
    else $error("timeout not applied");
  AST_HOLD: assert property (s_enter_menu |-> $past(hold_cnt) == HOLD_CYC - 28'h1)
    else $error("menu opened without full hold");
  AST_LOCK: assert property (state == ST_MENU && press && !knob_step && guarded && !param_en
    |=> refused && state == ST_MENU)
    else $error("locked value editable");
  AST_BUSY: assert property (state == ST_EDIT && press && !knob_step && guarded && busy
    |=> refused && !nv_we)
    else $error("change accepted while running");
  AST_DRY: assert property (!par.mode && !lv[`PLSC_LV_E] |=> pump_run == 3'h0)
    else $error("pump on at dry level");
  AST_FILL: assert property (par.mode && lv[`PLSC_LV_B] |=> pump_run == 3'h0)
    else $error("fill pump on at stop level");
  AST_COUNT: assert property (state != ST_LAMP |-> par.count != 2'h0)
    else $error("pump count out of range");

endmodule // plsc_top

// ==== testbench/plsc_tank.sv ====
`timescale 1ns/100ps
// ==========================================
// Wet well with five stacked float switches
module plsc_tank
(
  input wire logic [2:0] height,
  input wire logic [4:0] glitch,
  output logic [4:0] level_raw
);
  // A switch closes once water reaches it; bit 0 sits lowest.
  // The glitch mask lets the bench chatter contacts on purpose.
  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      level_raw[i] = (int'(height) > i) ^ glitch[i];
    end
  end
endmodule // plsc_tank

// ==== testbench/tb_pump_level_switch_control.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g); \
    end \
  end

module tb_pump_level_switch_control
  import plsc_pkg::*;
;
  typedef struct {string nm; logic [7:0] e;} plsc_note_t;
  logic core_clk;
  logic resetn;
  logic [2:0] height;
  logic [4:0] glitch;
  logic [4:0] level_raw;
  logic btn_raw;
  logic knob_step;
  logic knob_dir;
  logic [2:0] pump_run;
  logic [3:0] lamp;
  logic alarm_high;
  logic alarm_low;
  logic [4:0] level_disp;
  logic standby_ind;
  logic backlight;
  plsc_state_t ui_state;
  logic [1:0] menu_item;
  logic [1:0] edit_val;
  logic param_unlocked;
  logic refused;
  plsc_params_t params;
  int error_cnt = 0;
  int checked = 0;
  logic [7:0] ref_cnt = 8'h00;
  integer seed;
  plsc_note_t q[$];
  logic [2:0] dh [7] = '{3'h3, 3'h4, 3'h2, 3'h1, 3'h0, 3'h5, 3'h1};
  logic [2:0] dp [7] = '{3'h1, 3'h3, 3'h3, 3'h0, 3'h0, 3'h3, 3'h0};
  logic [2:0] fh [4] = '{3'h4, 3'h3, 3'h2, 3'h1};
  logic [2:0] fp [4] = '{3'h0, 3'h0, 3'h1, 3'h7};

  plsc_tank u_tank (.height(height), .glitch(glitch), .level_raw(level_raw));

  // Short counts keep the run small; all expectations follow these values
  plsc_top #(.LAMP_CYC(28'h28), .HOLD_CYC(28'h14), .IDLE_CYC(36'hc8), .DEB_CYC(20'h3)) u_dut (
    .core_clk(core_clk), .resetn(resetn), .level_raw(level_raw), .btn_raw(btn_raw),
    .knob_step(knob_step), .knob_dir(knob_dir), .pump_run(pump_run), .lamp(lamp),
    .alarm_high(alarm_high), .alarm_low(alarm_low), .level_disp(level_disp),
    .standby_ind(standby_ind), .backlight(backlight), .ui_state(ui_state),
    .menu_item(menu_item), .edit_val(edit_val), .param_unlocked(param_unlocked),
    .refused(refused), .params(params)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Refusals are one-cycle pulses, so they are tallied as they happen
  always @(posedge core_clk)
    if (refused === 1'b1)
      ref_cnt <= ref_cnt + 8'h01;

  // ==========================================
  // Scoreboard
  function automatic logic [7:0] obs(string nm);
    case (nm)
      "pump": return {5'h0, pump_run};
      "lamp": return {4'h0, lamp};
      "stby": return {7'h0, standby_ind};
      "bl": return {7'h0, backlight};
      "ui": return {6'h0, ui_state};
      "item": return {6'h0, menu_item};
      "edit": return {6'h0, edit_val};
      "unl": return {7'h0, param_unlocked};
      "mode": return {7'h0, params.mode};
      "cnt": return {6'h0, params.count};
      "lvl": return {3'h0, level_disp};
      "alrm": return {6'h0, alarm_high, alarm_low};
      default: return ref_cnt;
    endcase
  endfunction

  initial
  begin
    plsc_note_t n;
    forever
    begin
      wait (q.size() > 0);
      n = q.pop_front();
      `CHK(n.nm, n.e, obs(n.nm))
    end
  end

  task automatic note(input string nm, input logic [7:0] e);
    q.push_back('{nm, e});
  endtask

  task automatic end_of_test();
    #1;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================
  // Drivers
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic press(input int n);
    btn_raw = 1'b1;
    cyc(n);
    btn_raw = 1'b0;
    cyc(8);
  endtask

  task automatic turn(input logic d);
    knob_dir = d;
    knob_step = 1'b1;
    cyc(1);
    knob_step = 1'b0;
    knob_dir = 1'($random(seed));
    cyc(2);
  endtask

  task automatic wait_ui(input plsc_state_t st, input int n);
    int k;
    k = 0;
    while (ui_state !== st && k < n)
    begin
      cyc(1);
      k++;
    end
    if (ui_state !== st)
    begin
      error_cnt++;
      end_of_test();
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    seed = 32'h54d0;
    resetn = 1'b0;
    height = 3'h0;
    glitch = 5'h0;
    btn_raw = 1'b0;
    knob_step = 1'b0;
    knob_dir = 1'b0;
    repeat (20) @(posedge core_clk);
    #2;
    resetn = 1'b1;
    cyc(10);
    note("lamp", 8'h0f);
    note("stby", 8'h00);
    wait_ui(ST_MAIN, 60);
    cyc(2);
    note("stby", 8'h01);
    note("cnt", 8'h02);
    note("mode", 8'h00);
    foreach (dh[i])
    begin
      height = dh[i];
      cyc(8);
      note("pump", {5'h0, dp[i]});
      note("lamp", {4'h0, dh[i] == 3'h5, dp[i]});
      note("lvl", 8'((1 << dh[i]) - 1));
      note("alrm", {6'h0, dh[i] == 3'h5, dh[i] == 3'h0});
    end
    // Contact chatter shorter than the debounce time must vanish
    glitch = 5'($random(seed)) | 5'h01;
    cyc(2);
    glitch = 5'h0;
    cyc(6);
    note("lvl", 8'h01);
    press(8);
    note("ui", 8'(ST_MAIN));
    press(30);
    note("ui", 8'(ST_MENU));
    note("item", 8'h00);
    press(6);
    note("ref", 8'h01);
    turn(1'b1);
    turn(1'b1);
    note("item", 8'h02);
    press(6);
    note("ui", 8'(ST_EDIT));
    note("edit", 8'h00);
    turn(1'b1);
    press(6);
    note("unl", 8'h01);
    turn(1'b0);
    press(6);
    note("edit", 8'h02);
    // Two steps down from two must wrap round to three
    turn(1'b0);
    turn(1'b0);
    note("edit", 8'h03);
    press(6);
    note("cnt", 8'h03);
    turn(1'b0);
    press(6);
    turn(1'b1);
    press(6);
    note("mode", 8'h01);
    note("pump", 8'h07);
    foreach (fh[i])
    begin
      height = fh[i];
      cyc(8);
      note("pump", {5'h0, fp[i]});
    end
    // Pumps now run, so the protected setting must be turned away
    press(6);
    note("ref", 8'h02);
    note("ui", 8'(ST_MENU));
    // Edit opened while pumps stand, then they start: the save must be turned away
    height = 3'h4;
    cyc(8);
    press(6);
    note("ui", 8'(ST_EDIT));
    turn(1'b1);
    height = 3'h1;
    cyc(8);
    press(6);
    note("ref", 8'h03);
    note("ui", 8'(ST_MENU));
    note("mode", 8'h01);
    turn(1'b0);
    note("item", 8'h03);
    press(6);
    note("ui", 8'(ST_MAIN));
    press(30);
    note("ui", 8'(ST_MENU));
    cyc(230);
    note("bl", 8'h00);
    note("ui", 8'(ST_MAIN));
    note("unl", 8'h00);
    turn(1'b1);
    note("bl", 8'h01);
    resetn = 1'b0;
    cyc(3);
    resetn = 1'b1;
    cyc(5);
    note("lamp", 8'h0f);
    wait_ui(ST_MAIN, 60);
    cyc(2);
    note("mode", 8'h01);
    note("cnt", 8'h03);
    note("unl", 8'h00);
    end_of_test();
  end
endmodule // tb_pump_level_switch_control
